/* rtl/scg_clkout.sv */
module scg_clkout (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic en,
   output logic pin
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic pin; // Output level
   } scg_clkout_type;

   scg_clkout_type s;      // Registered state
   scg_clkout_type next_s; // Next state

   // Enable only acts while low; a high phase always completes,
   // so a late disable costs one extra pulse rather than a runt.
   always_comb begin
      next_s = s;
      if (tick) begin
         if (s.pin) begin
            next_s.pin = 1'b0;
         end else if (en) begin
            next_s.pin = 1'b1;
         end
      end
   end

   // Single register stage
   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign pin = s.pin;

   // Level changes only on a source edge, and rises only if enabled
   a_clkout_whole: assert property (@(posedge clk) disable iff (rst)
      (s.pin != $past(s.pin)) |-> $past(tick) &&
      ($past(s.pin) || $past(en)))
      else $error("clock output changed without a full source phase");

endmodule : scg_clkout

/* rtl/scg_pkg.sv */
// Behaviour
// - Machine cycle from fx/4, fx/8, fx/64, sub_osc_freq/4
// - One CPU cycle pulse per machine cycle
// - Clock output pin shows only whole pulses
// - STOP accepted only on main system clock
// - HALT accepted on either system clock
// - STOP halts main oscillator only
// - HALT gates only the CPU clock
// - Interval timer runs in HALT, not STOP
// - STOP: serial runs only on external clock
// - HALT: serial runs on main or external
// - STOP: counter runs only on pin source
// - HALT: counter runs on main or pin
// - Watch timer: STOP needs subsystem, HALT runs
// - Display: STOP needs subsystem, HALT runs
// - Converter off in STOP, on in HALT
// - STOP keeps external irqs one, two, three
// - Enabled request or reset ends standby
package scg_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_PROC_CLK = 8'h00; // Machine cycle select
   localparam logic [7:0] OFF_SYS_CLK = 8'h04;  // System clock select
   localparam logic [7:0] OFF_CLKOUT = 8'h08;   // Clock output control
   localparam logic [7:0] OFF_PERIPH = 8'h0C;   // Peripheral clock sources
   localparam logic [7:0] OFF_IRQ_EN = 8'h10;   // Wake enable flags
   localparam logic [7:0] OFF_STATUS = 8'h14;   // Read-only mode state

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int CLKOUT_EN_BIT = 0;  // Output enable
   localparam int CLKOUT_SRC_BIT = 1; // 0 main osc, 1 subsystem osc
   localparam int SIO_EXT_BIT = 0;    // Serial shift clock from pin
   localparam int TMR_EXT_BIT = 1;    // Counter source from pin
   localparam int WATCH_SUB_BIT = 2;  // Watch timer on subsystem
   localparam int LCD_SUB_BIT = 3;    // Display clock on subsystem
   localparam int ST_HALT_BIT = 0;    // Status: in HALT
   localparam int ST_STOP_BIT = 1;    // Status: in STOP
   localparam int ST_MAIN_BIT = 2;    // Status: main oscillator on
   localparam int ST_SUB_BIT = 3;     // Status: running on subsystem

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [1:0] PROC_RESET = 2'h0;   // Slowest main rate
   localparam logic SYS_RESET = 1'b0;          // Main system clock
   localparam logic [3:0] PERIPH_RESET = 4'h0; // Internal sources
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;
   localparam int NUM_IRQ = 8;                 // Wake request lines

   // ----------------------------------------------------------------
   // Divider terminal counts (oscillator edges per cycle, minus one)
   // ----------------------------------------------------------------
   localparam logic [5:0] TC_DIV64 = 6'h3F; // 15.3 us at 4.19 MHz
   localparam logic [5:0] TC_DIV8 = 6'h07;  // 1.91 us at 4.19 MHz
   localparam logic [5:0] TC_DIV4 = 6'h03;  // 0.95 us at 4.19 MHz
   localparam logic [5:0] TC_SUB = 6'h03;   // 122 us at 32.768 kHz

   // ----------------------------------------------------------------
   // Standby modes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_HALT,
      MODE_STOP
   } scg_mode_type;

endpackage : scg_pkg

/* rtl/scg_standby_ctrl.sv */
module scg_standby_ctrl (
   input wire logic MCLK,
   input wire logic RST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Oscillator pins, asynchronous
   input wire logic MAIN_OSC_TICK,
   input wire logic SUB_OSC_TICK,
   // CPU core and peripherals, same clock
   input wire logic STOP_REQ,
   input wire logic HALT_REQ,
   input wire logic [7:0] IRQ_REQ,
   output logic CPU_CYCLE,
   output logic CPU_RUN,
   output logic MAIN_OSC_EN,
   output logic BT_RUN,
   output logic SIO_RUN,
   output logic TMR_RUN,
   output logic WATCH_RUN,
   output logic LCD_RUN,
   output logic ADC_RUN,
   output logic [3:0] EXT_IRQ_EN,
   output logic CLOCK_OUT_PIN
);

   // ----------------------------------------------------------------
   // State record
   // ----------------------------------------------------------------
   typedef struct packed {
      logic main_s1;                  // Main tick sync, stage one
      logic main_s2;                  // Main tick sync, stage two
      logic main_s3;                  // Main tick edge history
      logic sub_s1;                   // Sub tick sync, stage one
      logic sub_s2;                   // Sub tick sync, stage two
      logic sub_s3;                   // Sub tick edge history
      logic [1:0] proc_sel;           // Machine cycle rate
      logic sys_sel;                  // 1 runs on subsystem clock
      logic clkout_en;                // Clock output enable
      logic clkout_src;               // Clock output source
      logic [3:0] periph_cfg;         // Peripheral source choices
      logic [7:0] irq_en;             // Wake enable flags
      scg_pkg::scg_mode_type mode;    // Standby mode
      logic [5:0] div_cnt;            // Machine cycle divider
      logic cpu_cycle;                // Machine cycle pulse
      logic cpu_run;                  // CPU allowed to execute
      logic main_osc_en;              // Main oscillator enable
      logic bt_run;                   // Interval timer enable
      logic sio_run;                  // Serial interface enable
      logic tmr_run;                  // Timer/event counter enable
      logic watch_run;                // Watch timer enable
      logic lcd_run;                  // Display controller enable
      logic adc_run;                  // Converter enable
      logic [3:0] ext_irq_en;         // External irq detectors
      logic pready;                   // APB ready
      logic pslverr;                  // APB error
      logic [31:0] prdata;            // APB read data
   } scg_state_type;

   scg_state_type s;      // Registered state
   scg_state_type next_s; // Next state

   logic main_edge; // Usable main oscillator edge
   logic sub_edge;  // Usable subsystem oscillator edge
   logic out_tick;  // Clock output source edge

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Divider terminal count for the selected rate
   function automatic logic [5:0] term_of(input logic sys_sel,
                                          input logic [1:0] sel);
      logic [5:0] t;
      t = scg_pkg::TC_DIV64;
      if (sys_sel) begin
         t = scg_pkg::TC_SUB;
      end else begin
         case (sel)
            2'h0: t = scg_pkg::TC_DIV64;
            2'h1: t = scg_pkg::TC_DIV8;
            default: t = scg_pkg::TC_DIV4;
         endcase
      end
      return t;
   endfunction : term_of

   // Address decode: one for a mapped word
   function automatic logic addr_ok(input logic [7:0] a);
      return (a == scg_pkg::OFF_PROC_CLK) || (a == scg_pkg::OFF_SYS_CLK)
         || (a == scg_pkg::OFF_CLKOUT) || (a == scg_pkg::OFF_PERIPH)
         || (a == scg_pkg::OFF_IRQ_EN) || (a == scg_pkg::OFF_STATUS);
   endfunction : addr_ok

   // Read multiplexer
   function automatic logic [31:0] read_of(input scg_state_type st,
                                           input logic [7:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         scg_pkg::OFF_PROC_CLK: d[1:0] = st.proc_sel;
         scg_pkg::OFF_SYS_CLK: d[0] = st.sys_sel;
         scg_pkg::OFF_CLKOUT: begin
            d[scg_pkg::CLKOUT_EN_BIT] = st.clkout_en;
            d[scg_pkg::CLKOUT_SRC_BIT] = st.clkout_src;
         end
         scg_pkg::OFF_PERIPH: d[3:0] = st.periph_cfg;
         scg_pkg::OFF_IRQ_EN: d[7:0] = st.irq_en;
         scg_pkg::OFF_STATUS: begin
            d[scg_pkg::ST_HALT_BIT] = (st.mode == scg_pkg::MODE_HALT);
            d[scg_pkg::ST_STOP_BIT] = (st.mode == scg_pkg::MODE_STOP);
            d[scg_pkg::ST_MAIN_BIT] = st.main_osc_en;
            d[scg_pkg::ST_SUB_BIT] = st.sys_sel;
         end
         default: d = 32'h0000_0000;
      endcase
      return d;
   endfunction : read_of

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic stop_n;    // Next mode is STOP
      logic wake;      // Enabled request pending
      logic setup;     // APB setup cycle
      logic wr;        // APB write taking effect
      logic [5:0] tc;  // Current terminal count
      logic cyc_edge;  // Edge feeding the divider
      stop_n = 1'b0;
      wake = 1'b0;
      setup = 1'b0;
      wr = 1'b0;
      tc = 6'h00;
      cyc_edge = 1'b0;
      next_s = s;

      // Two-flop synchronisers; the third flop only feeds edge detect
      next_s.main_s1 = MAIN_OSC_TICK;
      next_s.main_s2 = s.main_s1;
      next_s.main_s3 = s.main_s2;
      next_s.sub_s1 = SUB_OSC_TICK;
      next_s.sub_s2 = s.sub_s1;
      next_s.sub_s3 = s.sub_s2;

      // Divider keeps turning in HALT so wake resumes on phase
      tc = term_of(s.sys_sel, s.proc_sel);
      cyc_edge = s.sys_sel ? sub_edge : main_edge;
      next_s.cpu_cycle = 1'b0;
      if (cyc_edge) begin
         if (s.div_cnt >= tc) begin
            next_s.div_cnt = 6'h00;
            next_s.cpu_cycle = (s.mode == scg_pkg::MODE_RUN);
         end else begin
            next_s.div_cnt = s.div_cnt + 6'h01;
         end
      end

      // Standby sequencing; a request with wake pending still enters
      wake = |(IRQ_REQ & s.irq_en);
      case (s.mode)
         scg_pkg::MODE_RUN: begin
            if (STOP_REQ && !s.sys_sel) begin
               next_s.mode = scg_pkg::MODE_STOP;
            end else if (HALT_REQ) begin
               next_s.mode = scg_pkg::MODE_HALT;
            end
         end
         scg_pkg::MODE_HALT, scg_pkg::MODE_STOP: begin
            if (wake) begin
               next_s.mode = scg_pkg::MODE_RUN;
            end
         end
         default: next_s.mode = scg_pkg::MODE_RUN;
      endcase
      // No cycle pulse on the edge that enters standby
      next_s.cpu_cycle = next_s.cpu_cycle &&
         (next_s.mode == scg_pkg::MODE_RUN);

      // Peripheral gating follows the mode being entered
      stop_n = (next_s.mode == scg_pkg::MODE_STOP);
      // HALT and STOP both gate the CPU clock
      next_s.cpu_run = (next_s.mode == scg_pkg::MODE_RUN);
      next_s.main_osc_en = !stop_n;
      next_s.bt_run = !stop_n;
      // Outside STOP the main oscillator runs, so internal source works
      next_s.sio_run = !stop_n ||
         s.periph_cfg[scg_pkg::SIO_EXT_BIT];
      next_s.tmr_run = !stop_n ||
         s.periph_cfg[scg_pkg::TMR_EXT_BIT];
      next_s.watch_run = !stop_n ||
         s.periph_cfg[scg_pkg::WATCH_SUB_BIT];
      next_s.lcd_run = !stop_n ||
         s.periph_cfg[scg_pkg::LCD_SUB_BIT];
      next_s.adc_run = !stop_n;
      next_s.ext_irq_en = {3'h7, !stop_n};

      // APB: answer in the access cycle, write at its edge
      setup = PSEL && !PENABLE;
      wr = PSEL && PENABLE && s.pready && PWRITE && !s.pslverr;
      next_s.pready = setup;
      if (setup) begin
         next_s.prdata = read_of(s, PADDR);
         // Status is read-only; unmapped words answer with an error
         next_s.pslverr = !addr_ok(PADDR) ||
            (PWRITE && PADDR == scg_pkg::OFF_STATUS);
      end else if (!(PSEL && PENABLE)) begin
         next_s.pslverr = 1'b0;
         next_s.prdata = 32'h0000_0000;
      end
      if (wr) begin
         case (PADDR)
            scg_pkg::OFF_PROC_CLK: next_s.proc_sel = PWDATA[1:0];
            scg_pkg::OFF_SYS_CLK: next_s.sys_sel = PWDATA[0];
            scg_pkg::OFF_CLKOUT: begin
               next_s.clkout_en = PWDATA[scg_pkg::CLKOUT_EN_BIT];
               next_s.clkout_src = PWDATA[scg_pkg::CLKOUT_SRC_BIT];
            end
            scg_pkg::OFF_PERIPH: next_s.periph_cfg = PWDATA[3:0];
            scg_pkg::OFF_IRQ_EN: next_s.irq_en = PWDATA[7:0];
            default: next_s.irq_en = s.irq_en;
         endcase
      end
   end

   // Oscillator edges; a stopped main oscillator gives none
   assign main_edge = s.main_s2 && !s.main_s3 &&
      (s.mode != scg_pkg::MODE_STOP);
   assign sub_edge = s.sub_s2 && !s.sub_s3;
   assign out_tick = s.clkout_src ? sub_edge : main_edge;

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (RST) begin
         s <= '0;
         s.proc_sel <= scg_pkg::PROC_RESET;
         s.sys_sel <= scg_pkg::SYS_RESET;
         s.periph_cfg <= scg_pkg::PERIPH_RESET;
         s.irq_en <= scg_pkg::IRQ_EN_RESET;
         s.mode <= scg_pkg::MODE_RUN;
         s.cpu_run <= 1'b1;
         s.main_osc_en <= 1'b1;
         s.bt_run <= 1'b1;
         s.sio_run <= 1'b1;
         s.tmr_run <= 1'b1;
         s.watch_run <= 1'b1;
         s.lcd_run <= 1'b1;
         s.adc_run <= 1'b1;
         s.ext_irq_en <= 4'hF;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------
   // Clock output gate
   // ----------------------------------------------------------------
   scg_clkout u_clkout (
      .clk(MCLK),
      .rst(RST),
      .tick(out_tick),
      .en(s.clkout_en),
      .pin(CLOCK_OUT_PIN)
   );

   // ----------------------------------------------------------------
   // Outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign PRDATA = s.prdata;
   assign PREADY = s.pready;
   assign PSLVERR = s.pslverr;
   assign CPU_CYCLE = s.cpu_cycle;
   assign CPU_RUN = s.cpu_run;
   assign MAIN_OSC_EN = s.main_osc_en;
   assign BT_RUN = s.bt_run;
   assign SIO_RUN = s.sio_run;
   assign TMR_RUN = s.tmr_run;
   assign WATCH_RUN = s.watch_run;
   assign LCD_RUN = s.lcd_run;
   assign ADC_RUN = s.adc_run;
   assign EXT_IRQ_EN = s.ext_irq_en;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   // Running, with a STOP request
   sequence q_run_stop_req;
      (s.mode == scg_pkg::MODE_RUN) && STOP_REQ;
   endsequence

   a_stop_sub_refused: assert property (
      q_run_stop_req and s.sys_sel |=> s.mode != scg_pkg::MODE_STOP)
      else $error("STOP taken while on subsystem clock");

   a_stop_main_taken: assert property (
      q_run_stop_req and !s.sys_sel |=> s.mode == scg_pkg::MODE_STOP)
      else $error("STOP refused while on main clock");

   a_halt_entry: assert property (
      (s.mode == scg_pkg::MODE_RUN) && HALT_REQ &&
      !(STOP_REQ && !s.sys_sel) |=> s.mode == scg_pkg::MODE_HALT)
      else $error("HALT not entered");

   a_wake_exit: assert property (
      (s.mode != scg_pkg::MODE_RUN) && |(IRQ_REQ & s.irq_en)
      |=> CPU_RUN && s.mode == scg_pkg::MODE_RUN)
      else $error("enabled request did not end standby");

   a_standby_holds: assert property (
      (s.mode != scg_pkg::MODE_RUN) && !(|(IRQ_REQ & s.irq_en))
      |=> $stable(s.mode))
      else $error("standby left without enabled request");

   a_cpu_suspended: assert property (
      (s.mode != scg_pkg::MODE_RUN) |-> !CPU_RUN && !CPU_CYCLE)
      else $error("CPU active in standby");

   a_stop_osc_gating: assert property (
      (s.mode == scg_pkg::MODE_STOP) |-> !MAIN_OSC_EN && WATCH_RUN ==
      s.periph_cfg[scg_pkg::WATCH_SUB_BIT])
      else $error("STOP oscillator gating wrong");

   a_halt_all_osc: assert property (
      (s.mode == scg_pkg::MODE_HALT) |-> MAIN_OSC_EN && BT_RUN &&
      WATCH_RUN && LCD_RUN && ADC_RUN && SIO_RUN && TMR_RUN)
      else $error("HALT stopped more than the CPU clock");

   a_stop_periph: assert property (
      (s.mode == scg_pkg::MODE_STOP) |-> !BT_RUN && !ADC_RUN &&
      SIO_RUN == s.periph_cfg[scg_pkg::SIO_EXT_BIT] &&
      TMR_RUN == s.periph_cfg[scg_pkg::TMR_EXT_BIT] &&
      LCD_RUN == s.periph_cfg[scg_pkg::LCD_SUB_BIT])
      else $error("peripheral gating wrong in STOP");

   a_stop_ext_irq: assert property (
      (s.mode == scg_pkg::MODE_STOP) |-> EXT_IRQ_EN == 4'hE)
      else $error("external irq gating wrong in STOP");

   // Oscillator edges are at least two clocks apart, divider >= 4
   a_cycle_spacing: assert property (
      CPU_CYCLE |=> !CPU_CYCLE [*6])
      else $error("machine cycles too close");

endmodule : scg_standby_ctrl

/* verif/scg_far_model.sv */
// ----------------------------------------------------------------
// Oscillators and cycle observer on the far side of the block
// ----------------------------------------------------------------
module scg_far_model (
   input wire logic clk,
   input wire logic osc_en,
   input wire logic cycle,
   input wire logic on_sub,
   output logic main_tick,
   output logic sub_tick,
   output int gap
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev; // Last sampled level of the watched source
   logic s; // Watched source this cycle
   int edges; // Rising edges since the last machine cycle
   initial begin
      main_tick = 1'b0;
      sub_tick = 1'b0;
      prev = 1'b0;
      edges = 0;
      gap = 0;
   end
   // Main crystal, 4.19 MHz; it freezes once its enable drops
   always begin
      #119.3;
      if (osc_en === 1'b1) begin
         main_tick = ~main_tick;
      end
   end
   // Subsystem crystal, 32.768 kHz, never stopped
   always begin
      #15259;
      sub_tick = ~sub_tick;
   end
   // Source edges per machine cycle; sampled at MCLK, slower than it
   always @(posedge clk) begin
      s = on_sub ? sub_tick : main_tick;
      if (s && !prev) begin
         edges++;
      end
      prev = s;
      if (cycle === 1'b1) begin
         gap = edges;
         edges = 0;
      end
   end
endmodule : scg_far_model

/* verif/standby_clock_gating_ctrl_tb.sv */
module standby_clock_gating_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------------
   logic MCLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0;
   logic PWRITE = 1'b0, STOP_REQ = 1'b0, HALT_REQ = 1'b0, on_sub = 1'b0;
   logic [7:0] PADDR = 8'h00, IRQ_REQ = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic PREADY, PSLVERR, CPU_CYCLE, CPU_RUN, MAIN_OSC_EN, BT_RUN;
   logic SIO_RUN, TMR_RUN, WATCH_RUN, LCD_RUN, ADC_RUN, CLOCK_OUT_PIN;
   logic MAIN_OSC_TICK, SUB_OSC_TICK, er;
   logic [3:0] EXT_IRQ_EN;
   int gap, hi = 0, pulses = 0, cycles = 0, n;
   int miscompares = 0, num_checks = 0;
   int divs[3] = '{64, 8, 4}; // Main edges per cycle, PROC 0..2
   logic [3:0] pv[4] = '{4'h0, 4'h5, 4'hA, 4'hF}; // Source mixes
   always #50 MCLK = ~MCLK;
   scg_standby_ctrl dut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .MAIN_OSC_TICK(MAIN_OSC_TICK), .SUB_OSC_TICK(SUB_OSC_TICK),
      .STOP_REQ(STOP_REQ), .HALT_REQ(HALT_REQ), .IRQ_REQ(IRQ_REQ),
      .CPU_CYCLE(CPU_CYCLE), .CPU_RUN(CPU_RUN), .MAIN_OSC_EN(MAIN_OSC_EN),
      .BT_RUN(BT_RUN), .SIO_RUN(SIO_RUN), .TMR_RUN(TMR_RUN),
      .WATCH_RUN(WATCH_RUN), .LCD_RUN(LCD_RUN), .ADC_RUN(ADC_RUN),
      .EXT_IRQ_EN(EXT_IRQ_EN), .CLOCK_OUT_PIN(CLOCK_OUT_PIN));
   scg_far_model far (.clk(MCLK), .osc_en(MAIN_OSC_EN),
      .cycle(CPU_CYCLE), .on_sub(on_sub), .main_tick(MAIN_OSC_TICK),
      .sub_tick(SUB_OSC_TICK), .gap(gap));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task check(input string nm, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   // One APB transfer; request held until PREADY is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do @(posedge MCLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(nm, rd, e);
   endtask : rdchk
   // One-cycle standby request, then let the gating settle
   task req(input logic stop);
      @(posedge MCLK);
      if (stop) STOP_REQ <= 1'b1;
      else HALT_REQ <= 1'b1;
      @(posedge MCLK);
      STOP_REQ <= 1'b0;
      HALT_REQ <= 1'b0;
      repeat (2) @(posedge MCLK);
   endtask : req
   // Raise one request line; wake is one cycle after it is seen
   task wake(input int k, input logic e);
      @(posedge MCLK);
      IRQ_REQ[k] <= 1'b1;
      repeat (4) @(posedge MCLK);
      check("wake", CPU_RUN, e);
      IRQ_REQ <= 8'h00;
   endtask : wake
   task cyc(input int c);
      repeat (c) do @(posedge MCLK); while (CPU_CYCLE !== 1'b1);
      #1;
   endtask : cyc
   task results;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results
   // Pin watcher: every complete high phase lasts at least two MCLK cycles
   always @(posedge MCLK) begin
      if (CLOCK_OUT_PIN === 1'b1) hi++;
      else begin
         if (hi > 0) begin
            pulses++;
            check("pulse width", hi >= 2, 1);
         end
         hi = 0;
      end
   end
   // Hang guard; the whole run is well under this
   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         results;
      end
   end
   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge MCLK);
      RST <= 1'b0;
      @(posedge MCLK);
      check("reset outs", {CPU_RUN, MAIN_OSC_EN, BT_RUN, SIO_RUN, TMR_RUN,
         WATCH_RUN, LCD_RUN, ADC_RUN, EXT_IRQ_EN}, 12'hFFF);
      for (int i = 0; i < 5; i++) rdchk("reg reset", 8'(4 * i), 0);
      rdchk("status", scg_pkg::OFF_STATUS, 32'h4);
      apb(1'b0, 8'h18, 32'h0);
      check("unmapped", er, 1'b1);
      apb(1'b1, scg_pkg::OFF_STATUS, 32'hF);
      check("ro write", er, 1'b1);
      $display("test reset done");
      // Machine-cycle rates on the main clock, then the subsystem
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, scg_pkg::OFF_PROC_CLK, 32'(i));
         cyc(3);
         check("main gap", gap >= divs[i]-1 && gap <= divs[i]+1, 1);
      end
      apb(1'b1, scg_pkg::OFF_SYS_CLK, 32'h1);
      on_sub <= 1'b1;
      cyc(3);
      check("sub gap", gap >= 3 && gap <= 5, 1);
      rdchk("status sub", scg_pkg::OFF_STATUS, 32'hC);
      $display("test rates done");
      // STOP refused on subsystem, HALT taken there
      req(1'b1);
      check("stop refused", CPU_RUN, 1'b1);
      rdchk("status sub", scg_pkg::OFF_STATUS, 32'hC);
      req(1'b0);
      check("halt on sub", CPU_RUN, 1'b0);
      apb(1'b1, scg_pkg::OFF_IRQ_EN, 32'h02);
      wake(0, 1'b0);
      wake(1, 1'b1);
      apb(1'b1, scg_pkg::OFF_SYS_CLK, 32'h0);
      on_sub <= 1'b0;
      $display("test sub standby done");
      // STOP with each source mix for the peripherals
      foreach (pv[i]) begin
         apb(1'b1, scg_pkg::OFF_PERIPH, 32'(pv[i]));
         req(1'b1);
         check("stop off", {MAIN_OSC_EN, BT_RUN, ADC_RUN, CPU_RUN}, 0);
         check("stop keep", {LCD_RUN, WATCH_RUN, TMR_RUN, SIO_RUN}, pv[i]);
         check("stop irqs", EXT_IRQ_EN, 4'hE);
         rdchk("status stop", scg_pkg::OFF_STATUS, 32'h2);
         wake(1, 1'b1);
      end
      $display("test stop done");
      // HALT on main: only the CPU clock stops
      apb(1'b1, scg_pkg::OFF_PERIPH, 32'h0);
      req(1'b0);
      check("halt keep", {MAIN_OSC_EN, BT_RUN, SIO_RUN, TMR_RUN, WATCH_RUN,
         LCD_RUN, ADC_RUN, EXT_IRQ_EN}, 11'h7FF);
      n = 0;
      repeat (200) @(posedge MCLK) if (CPU_CYCLE === 1'b1) n++;
      check("halt cycles", n, 0);
      rdchk("status halt", scg_pkg::OFF_STATUS, 32'h5);
      @(posedge MCLK);
      RST <= 1'b1;
      repeat (2) @(posedge MCLK);
      RST <= 1'b0;
      @(posedge MCLK);
      check("reset wake", CPU_RUN, 1'b1);
      rdchk("status", scg_pkg::OFF_STATUS, 32'h4);
      $display("test halt done");
      // Clock pin toggled on and off at varied phases
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, scg_pkg::OFF_CLKOUT, 32'h1);
         repeat (i) @(posedge MCLK);
         apb(1'b1, scg_pkg::OFF_CLKOUT, 32'h0);
         repeat (i) @(posedge MCLK);
      end
      // Subsystem source for the pin, slow edges
      n = pulses;
      apb(1'b1, scg_pkg::OFF_CLKOUT, 32'h3);
      repeat (3000) @(posedge MCLK);
      apb(1'b1, scg_pkg::OFF_CLKOUT, 32'h2);
      repeat (3000) @(posedge MCLK);
      check("sub pulse", pulses > n, 1);
      repeat (10) @(posedge MCLK);
      check("pin idle", CLOCK_OUT_PIN, 1'b0);
      check("pin pulsed", pulses > 0, 1);
      $display("test clock out done");
      results;
   end
endmodule : standby_clock_gating_ctrl_tb
